// ---- src/sfw_pkg.sv ----
// Constants, register map and types for the supervisor flags and watchdog block.
package sfw_pkg;
   localparam int CLK_PERIOD_NS = 5;

   // Register byte addresses.
   localparam logic [7:0] ADDR_SUPPLY = 8'h00;
   localparam logic [7:0] ADDR_EVENT = 8'h04;
   localparam logic [7:0] ADDR_BUS = 8'h08;
   localparam logic [7:0] ADDR_WD_CTRL = 8'h0C;
   localparam logic [7:0] ADDR_WD_TRIG = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;

   // Rail index: battery, converter, regulator 2, regulator 3.
   localparam int RAIL_BATTERY = 0;
   localparam int RAIL_CONVERTER = 1;
   localparam int SUPPLY_UV_LSB = 0;
   localparam int SUPPLY_POK_LSB = 4;

   localparam int EV_BUS_WAKE = 0;
   localparam int EV_LOCAL_WAKE = 1;
   localparam int EV_OVT_WARN = 2;
   localparam int EV_OVERTEMP_RECOVERY_FLAG = 3;

   localparam int BUS_HIGH_TO_GROUND = 0;
   localparam int BUS_HIGH_TO_BATTERY = 1;
   localparam int BUS_LOW_TO_BATTERY = 2;
   localparam int BUS_LOW_TO_GROUND = 3;
   localparam int BUS_TXD_CLAMP = 4;
   localparam int BUS_TXD_RXD_SHORT = 5;
   localparam int BUS_DOM_CLAMP = 6;

   localparam int CTRL_PERIOD_LSB = 0;
   localparam logic [2:0] PERIOD_SEL_RST = 3'h0;
   localparam int STAT_STATE_LSB = 0;
   localparam int STAT_ATTEMPT_LSB = 2;
   localparam int STAT_TX_DISABLE = 4;
   localparam int STAT_SLEEP = 5;
   localparam int STAT_STANDBY = 6;
   localparam logic [1:0] LAST_ATTEMPT = 2'h2;

   // Times in ns and their cycle counts (least times rounded up).
   localparam int WAKE_REC_NS = 2000;
   localparam int WAKE_REC_CYC = (WAKE_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LOCAL_FILTER_NS = 10000;
   localparam int LOCAL_FILTER_CYC = (LOCAL_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SHORT_FILTER_NS [4] = '{2000, 2000, 2000, 2000};
   localparam int RECOVERY_PULSE_NS = 500;
   localparam int RECOVERY_PULSE_CYC = (RECOVERY_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESET_PULSE_NS = 2000;
   localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TXD_DOM_NS = 1000000;
   localparam int BUS_DOM_NS = 1000000;
   localparam int STARTUP_NS = 256000000;
   localparam int PERIOD_UNIT_NS = 4000000;

   typedef enum logic [1:0] {WD_STARTUP, WD_SERVED, WD_WINDOW, WD_SLEEP} sfw_wd_state_type;
endpackage : sfw_pkg

// ---- src/sfw_supervisor_flags_watchdog.sv ----
// Supply, wake, bus-fault flags and start-up/window watchdog with an Avalon-MM register slave.
`timescale 1ns/1ps
`default_nettype none
module sfw_supervisor_flags_watchdog #(
   parameter int TXD_DOM_CYC = (sfw_pkg::TXD_DOM_NS + sfw_pkg::CLK_PERIOD_NS - 1)
                               / sfw_pkg::CLK_PERIOD_NS,
   parameter int BUS_DOM_CYC = (sfw_pkg::BUS_DOM_NS + sfw_pkg::CLK_PERIOD_NS - 1)
                               / sfw_pkg::CLK_PERIOD_NS,
   parameter int STARTUP_CYC = sfw_pkg::STARTUP_NS / sfw_pkg::CLK_PERIOD_NS,
   parameter int PERIOD_UNIT_CYC = sfw_pkg::PERIOD_UNIT_NS / sfw_pkg::CLK_PERIOD_NS
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [3:0] rail_uv,
   input wire logic [3:0] rail_pok,
   input wire logic regulator1_uv,
   input wire logic temp_warn,
   input wire logic temp_recovered,
   input wire logic wake_remote,
   input wire logic wake_level,
   input wire logic [3:0] line_cmp,
   input wire logic txd,
   input wire logic rxd,
   input wire logic normal_mode,
   output logic interrupt_out_n,
   output logic reset_out_n,
   output logic standby_request,
   output logic sleep_request,
   output logic transceiver_off,
   output logic transmitter_disable
);
   // Register slave: one wait cycle, then the access is taken.
   logic ack_r;
   logic [31:0] readdata_r;
   logic [6:0] bus_seen_r;
   wire logic req = avs_read | avs_write;
   wire logic acc = req & ack_r & clk_en;
   wire logic rd_acc = avs_read & acc;
   wire logic wr_acc = avs_write & acc & avs_byteenable[0];
   wire logic wr_supply = wr_acc & (avs_address == sfw_pkg::ADDR_SUPPLY);
   wire logic wr_event = wr_acc & (avs_address == sfw_pkg::ADDR_EVENT);
   wire logic wr_ctrl = wr_acc & (avs_address == sfw_pkg::ADDR_WD_CTRL);
   wire logic wd_trig = wr_acc & (avs_address == sfw_pkg::ADDR_WD_TRIG);
   wire logic rd_bus = rd_acc & (avs_address == sfw_pkg::ADDR_BUS);
   assign avs_waitrequest = req & ~ack_r;
   assign avs_readdata = readdata_r;

   // Flag state.
   logic [3:0] uv_r, pok_r, pok_prev_r, ev_r;
   logic [6:0] bus_r;
   logic warn_prev_r, recov_prev_r, int_n_r;
   logic [3:0] ev_set;
   logic [6:0] bus_set;

   // Watchdog state.
   sfw_pkg::sfw_wd_state_type wd_state_r;
   logic [31:0] wd_cnt_r, rst_cnt_r;
   logic [1:0] attempts_r;
   logic [2:0] period_sel_r;
   logic reset_n_r, sleep_r, fire;

   // Transmit and bus clamp state.
   logic [31:0] txd_low_cnt_r, rxd_low_cnt_r;
   logic tx_clamp_r, short_r, txd_prev_r, rxd_prev_r, followed_r, good_pulse_r;

   wire logic [31:0] period_cyc = 32'(PERIOD_UNIT_CYC) << period_sel_r;
   wire logic window_open = wd_cnt_r >= (period_cyc >> 1);
   wire logic wd_run = ~regulator1_uv & reset_n_r;
   wire logic startup_expired = (wd_cnt_r == 32'(STARTUP_CYC - 1)) & ~wd_trig;

   wire logic [31:0] rd_mux =
      (avs_address == sfw_pkg::ADDR_SUPPLY) ? {24'h000000, pok_r, uv_r} :
      (avs_address == sfw_pkg::ADDR_EVENT) ? {28'h0000000, ev_r} :
      (avs_address == sfw_pkg::ADDR_BUS) ? {25'h0000000, bus_r} :
      (avs_address == sfw_pkg::ADDR_WD_CTRL) ? {29'h00000000, period_sel_r} :
      (avs_address == sfw_pkg::ADDR_STATUS) ?
         {25'h0000000, standby_request, sleep_r, transmitter_disable, attempts_r,
          2'(wd_state_r)} :
      32'h00000000;

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         ack_r <= 1'b0;
         readdata_r <= 32'h00000000;
         bus_seen_r <= 7'h00;
      end else if (clk_en) begin
         ack_r <= req & ~ack_r;
         if (avs_read & ~ack_r) begin
            readdata_r <= rd_mux;
            bus_seen_r <= bus_r;
         end
      end
   end

   // Supply flags: undervoltage is set by the comparators and held until power-ok, power-ok is a sticky event.
   wire logic [3:0] pok_clr = wr_supply ? avs_writedata[sfw_pkg::SUPPLY_POK_LSB +: 4] : 4'h0;
   wire logic [3:0] ev_clr = wr_event ? avs_writedata[3:0] : 4'h0;
   assign standby_request = uv_r[sfw_pkg::RAIL_BATTERY] | uv_r[sfw_pkg::RAIL_CONVERTER];
   assign transceiver_off = standby_request;
   assign transmitter_disable = tx_clamp_r | short_r;
   assign interrupt_out_n = int_n_r;
   assign reset_out_n = reset_n_r;
   assign sleep_request = sleep_r;

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         uv_r <= 4'h0;
         pok_r <= 4'h0;
         pok_prev_r <= 4'h0;
         ev_r <= 4'h0;
         bus_r <= 7'h00;
         warn_prev_r <= 1'b0;
         recov_prev_r <= 1'b0;
         int_n_r <= 1'b1;
      end else if (clk_en) begin
         uv_r <= rail_uv | (uv_r & ~rail_pok);
         pok_r <= (rail_pok & ~pok_prev_r) | (pok_r & ~pok_clr);
         pok_prev_r <= rail_pok;
         ev_r <= ev_set | (ev_r & ~ev_clr);
         bus_r <= bus_set | (bus_r & ~(rd_bus ? bus_seen_r : 7'h00));
         warn_prev_r <= temp_warn;
         recov_prev_r <= temp_recovered;
         int_n_r <= ~(|{uv_r, pok_r, ev_r, bus_r});
      end
   end

   assign ev_set[sfw_pkg::EV_OVT_WARN] = temp_warn & ~warn_prev_r;
   assign ev_set[sfw_pkg::EV_OVERTEMP_RECOVERY_FLAG] = temp_recovered & ~recov_prev_r;

   // Remote wake: dominant start, recessive of at least the minimum, second dominant start.
   logic rem_prev_r, rem_first_r;
   logic [15:0] rec_cnt_r;
   wire logic dom_start = rem_prev_r & ~wake_remote;
   wire logic rec_ok = rec_cnt_r == 16'(sfw_pkg::WAKE_REC_CYC);
   assign ev_set[sfw_pkg::EV_BUS_WAKE] = dom_start & rem_first_r & rec_ok;

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         rem_prev_r <= 1'b1;
         rem_first_r <= 1'b0;
         rec_cnt_r <= 16'h0000;
      end else if (clk_en) begin
         rem_prev_r <= wake_remote;
         if (!wake_remote) begin
            rec_cnt_r <= 16'h0000;
         end else if (!rec_ok) begin
            rec_cnt_r <= rec_cnt_r + 16'h0001;
         end
         if (dom_start) begin
            rem_first_r <= ~(rem_first_r & rec_ok);
         end
      end
   end

   // Local wake: the filter starts at the rising edge and fires once per high phase.
   logic [15:0] lw_cnt_r;
   assign ev_set[sfw_pkg::EV_LOCAL_WAKE] =
      wake_level & (lw_cnt_r == 16'(sfw_pkg::LOCAL_FILTER_CYC - 1));

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         lw_cnt_r <= 16'h0000;
      end else if (clk_en) begin
         if (!wake_level) begin
            lw_cnt_r <= 16'h0000;
         end else if (lw_cnt_r != 16'(sfw_pkg::LOCAL_FILTER_CYC)) begin
            lw_cnt_r <= lw_cnt_r + 16'h0001;
         end
      end
   end

   // Bus-line shorts: each comparator must stay high for its own filter time.
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_short
         localparam logic [15:0] FILT = 16'((sfw_pkg::SHORT_FILTER_NS[g]
                                   + sfw_pkg::CLK_PERIOD_NS - 1) / sfw_pkg::CLK_PERIOD_NS);
         logic [15:0] cnt_r;
         assign bus_set[g] = cnt_r == FILT;
         always_ff @(posedge sys_clk) begin
            if (!reset_n) begin
               cnt_r <= 16'h0000;
            end else if (clk_en) begin
               if (!line_cmp[g]) begin
                  cnt_r <= 16'h0000;
               end else if (cnt_r != FILT) begin
                  cnt_r <= cnt_r + 16'h0001;
               end
            end
         end
      end
   endgenerate

   // Transmit clamp, transmit-receive short and dominant bus clamp.
   wire logic txd_timeout = ~txd & (txd_low_cnt_r == 32'(TXD_DOM_CYC - 1));
   wire logic txd_rise = txd & ~txd_prev_r;
   wire logic short_seen = txd_rise & rxd & ~rxd_prev_r;
   wire logic pulse_ok = (txd_low_cnt_r >= 32'(sfw_pkg::RECOVERY_PULSE_CYC)) & ~followed_r;
   assign bus_set[sfw_pkg::BUS_TXD_CLAMP] = tx_clamp_r;
   assign bus_set[sfw_pkg::BUS_TXD_RXD_SHORT] = short_r;
   assign bus_set[sfw_pkg::BUS_DOM_CLAMP] = rxd_low_cnt_r == 32'(BUS_DOM_CYC);

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         txd_low_cnt_r <= 32'h00000000;
         rxd_low_cnt_r <= 32'h00000000;
         tx_clamp_r <= 1'b0;
         short_r <= 1'b0;
         txd_prev_r <= 1'b1;
         rxd_prev_r <= 1'b1;
         followed_r <= 1'b0;
         good_pulse_r <= 1'b0;
      end else if (clk_en) begin
         txd_prev_r <= txd;
         rxd_prev_r <= rxd;
         if (txd) begin
            txd_low_cnt_r <= 32'h00000000;
         end else if (txd_low_cnt_r != 32'(TXD_DOM_CYC)) begin
            txd_low_cnt_r <= txd_low_cnt_r + 32'h00000001;
         end
         if (rxd) begin
            rxd_low_cnt_r <= 32'h00000000;
         end else if (rxd_low_cnt_r != 32'(BUS_DOM_CYC)) begin
            rxd_low_cnt_r <= rxd_low_cnt_r + 32'h00000001;
         end
         followed_r <= txd ? 1'b0 : (followed_r | ~rxd);
         if (txd_timeout) begin
            tx_clamp_r <= 1'b1;
         end else if (tx_clamp_r && txd_rise) begin
            tx_clamp_r <= 1'b0;
            short_r <= short_seen;
            good_pulse_r <= 1'b0;
         end else if (short_r && txd_rise) begin
            // Recovery needs two clean low pulses that the receiver did not follow.
            good_pulse_r <= pulse_ok & ~good_pulse_r;
            short_r <= ~(pulse_ok & good_pulse_r);
         end
      end
   end

   // Watchdog: start-up attempts, window servicing and forced resets.
   always_comb begin
      fire = 1'b0;
      if (wd_run) begin
         case (wd_state_r)
            sfw_pkg::WD_STARTUP: fire = startup_expired & (attempts_r != sfw_pkg::LAST_ATTEMPT);
            sfw_pkg::WD_WINDOW: fire = normal_mode & ((wd_trig & ~window_open)
                               | (~wd_trig & (wd_cnt_r == period_cyc - 32'h00000001)));
            default: fire = 1'b0;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         rst_cnt_r <= 32'h00000000;
         reset_n_r <= 1'b1;
      end else if (clk_en) begin
         if (fire) begin
            rst_cnt_r <= 32'(sfw_pkg::RESET_PULSE_CYC);
         end else if (rst_cnt_r != 32'h00000000) begin
            rst_cnt_r <= rst_cnt_r - 32'h00000001;
         end
         reset_n_r <= ~(fire | (rst_cnt_r > 32'h00000001));
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         wd_state_r <= sfw_pkg::WD_STARTUP;
         wd_cnt_r <= 32'h00000000;
         attempts_r <= 2'h0;
         period_sel_r <= sfw_pkg::PERIOD_SEL_RST;
         sleep_r <= 1'b0;
      end else if (clk_en) begin
         if (wr_ctrl && (wd_state_r != sfw_pkg::WD_WINDOW || window_open)) begin
            period_sel_r <= avs_writedata[sfw_pkg::CTRL_PERIOD_LSB +: 3];
         end
         if (wd_run) begin
            case (wd_state_r)
               sfw_pkg::WD_STARTUP: begin
                  if (wd_trig) begin
                     attempts_r <= 2'h0;
                     wd_cnt_r <= 32'h00000000;
                     wd_state_r <= normal_mode ? sfw_pkg::WD_WINDOW : sfw_pkg::WD_SERVED;
                  end else if (startup_expired) begin
                     wd_cnt_r <= 32'h00000000;
                     if (attempts_r == sfw_pkg::LAST_ATTEMPT) begin
                        wd_state_r <= sfw_pkg::WD_SLEEP;
                        sleep_r <= 1'b1;
                     end else begin
                        attempts_r <= attempts_r + 2'h1;
                     end
                  end else begin
                     wd_cnt_r <= wd_cnt_r + 32'h00000001;
                  end
               end
               sfw_pkg::WD_SERVED: begin
                  if (normal_mode) begin
                     wd_state_r <= sfw_pkg::WD_WINDOW;
                     wd_cnt_r <= 32'h00000000;
                  end
               end
               sfw_pkg::WD_WINDOW: begin
                  if (!normal_mode) begin
                     wd_state_r <= sfw_pkg::WD_SERVED;
                  end else if (fire) begin
                     wd_state_r <= sfw_pkg::WD_STARTUP;
                     attempts_r <= 2'h0;
                     wd_cnt_r <= 32'h00000000;
                  end else if (wd_trig) begin
                     wd_cnt_r <= 32'h00000000;
                  end else begin
                     wd_cnt_r <= wd_cnt_r + 32'h00000001;
                  end
               end
               default: wd_state_r <= sfw_pkg::WD_SLEEP;
            endcase
         end
      end
   end

   property p_uv_set;
      @(posedge sys_clk) disable iff (!reset_n)
      clk_en && rail_uv[0] |=> uv_r[0] && standby_request && transceiver_off;
   endproperty
   a_uv_set: assert property (p_uv_set) else $error("battery undervoltage not flagged");

   property p_pok_rise;
      @(posedge sys_clk) disable iff (!reset_n)
      clk_en && $rose(rail_pok[1]) |=> pok_r[1];
   endproperty
   a_pok_rise: assert property (p_pok_rise) else $error("converter power-ok missed");

   property p_int;
      @(posedge sys_clk) disable iff (!reset_n)
      clk_en && (|bus_r) |=> !interrupt_out_n;
   endproperty
   a_int: assert property (p_int) else $error("interrupt not asserted for a flag");

   property p_set_wins;
      @(posedge sys_clk) disable iff (!reset_n)
      clk_en && bus_set[0] |=> bus_r[0];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("short flag lost on read");

   property p_txd_clamp;
      @(posedge sys_clk) disable iff (!reset_n)
      clk_en && txd_timeout |=> transmitter_disable ##1 (bus_r[4] || !clk_en);
   endproperty
   a_txd_clamp: assert property (p_txd_clamp) else $error("transmit clamp not taken");

   property p_wd_hold;
      @(posedge sys_clk) disable iff (!reset_n)
      regulator1_uv && wd_state_r != sfw_pkg::WD_SLEEP |=> $stable(wd_cnt_r);
   endproperty
   a_wd_hold: assert property (p_wd_hold) else $error("watchdog ran during undervoltage");

   property p_early;
      @(posedge sys_clk) disable iff (!reset_n)
      clk_en && wd_run && wd_state_r == sfw_pkg::WD_WINDOW && normal_mode && wd_trig
      && !window_open |=> !reset_out_n && wd_state_r == sfw_pkg::WD_STARTUP;
   endproperty
   a_early: assert property (p_early) else $error("early trigger did not reset");

   property p_sleep;
      @(posedge sys_clk) disable iff (!reset_n)
      clk_en && wd_run && wd_state_r == sfw_pkg::WD_STARTUP && startup_expired
      && attempts_r == sfw_pkg::LAST_ATTEMPT |=> sleep_request && reset_out_n;
   endproperty
   a_sleep: assert property (p_sleep) else $error("third start-up miss not sleep");

   property p_ack;
      @(posedge sys_clk) disable iff (!reset_n)
      clk_en && avs_waitrequest |=> !avs_waitrequest || !clk_en || !(avs_read || avs_write);
   endproperty
   a_ack: assert property (p_ack) else $error("register access waited too long");
endmodule : sfw_supervisor_flags_watchdog
`default_nettype wire

// ---- testbench/sfw_host_model.sv ----
// Host microcontroller model: Avalon-MM master, watchdog service and transmit pulses.
`timescale 1ns/1ps
`default_nettype none
module sfw_host_model (
   input wire logic sys_clk,
   input wire logic avs_waitrequest,
   input wire logic [31:0] avs_readdata,
   output logic [7:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [31:0] avs_writedata,
   output logic txd,
   output logic stuck
);
   initial begin
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h00000000;
      txd = 1'b1;
      stuck = 1'b0;
   end
   // The request stands until waitrequest is seen low at a rising edge; released data is inverted.
   task automatic access(input logic rd, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      int n;
      begin
         n = 0;
         avs_address <= a;
         avs_writedata <= d;
         avs_read <= rd;
         avs_write <= ~rd;
         @(posedge sys_clk);
         while (avs_waitrequest !== 1'b0 && n < 50) begin
            @(posedge sys_clk);
            n++;
         end
         if (n == 50) stuck = 1'b1;
         q = avs_readdata;
         avs_read <= 1'b0;
         avs_write <= 1'b0;
         avs_writedata <= ~d;
         @(posedge sys_clk);
      end
   endtask : access
   task automatic trigger();
      logic [31:0] q;
      begin
         access(1'b0, sfw_pkg::ADDR_WD_TRIG, 32'h00000001, q);
      end
   endtask : trigger
   task automatic txd_low(input int n);
      begin
         txd <= 1'b0;
         repeat (n) @(posedge sys_clk);
         txd <= 1'b1;
      end
   endtask : txd_low
   // Two low pulses with an equal high gap test whether a transmit-receive short has gone.
   task automatic probe_short();
      begin
         txd_low(sfw_pkg::RECOVERY_PULSE_CYC);
         repeat (sfw_pkg::RECOVERY_PULSE_CYC) @(posedge sys_clk);
         txd_low(sfw_pkg::RECOVERY_PULSE_CYC);
      end
   endtask : probe_short
endmodule : sfw_host_model
`default_nettype wire

// ---- testbench/sfw_supervisor_flags_watchdog_bench.sv ----
// Self-checking bench for the supervisor flags and watchdog block.
`timescale 1ns/1ps
`default_nettype none
module sfw_supervisor_flags_watchdog_bench;
   logic sys_clk = 1'b0, reset_n = 1'b0, regulator1_uv = 1'b0, temp_warn = 1'b0;
   logic temp_recovered = 1'b0, wake_remote = 1'b1, wake_level = 1'b0, rxd = 1'b1;
   logic normal_mode = 1'b0, clk_en = 1'b1, lo;
   logic [3:0] rail_uv = 4'h0, rail_pok = 4'h0, line_cmp = 4'h0, avs_byteenable = 4'hF;
   logic [7:0] avs_address;
   logic avs_read, avs_write, avs_waitrequest, txd, stuck, interrupt_out_n, reset_out_n;
   logic standby_request, sleep_request, transceiver_off, transmitter_disable;
   logic [31:0] avs_writedata, avs_readdata, q;
   int n_fail = 0, checks = 0, k;
   sfw_supervisor_flags_watchdog #(.TXD_DOM_CYC(150), .BUS_DOM_CYC(50), .STARTUP_CYC(200),
      .PERIOD_UNIT_CYC(64)) uut (.sys_clk, .reset_n, .clk_en, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
      .rail_uv, .rail_pok, .regulator1_uv, .temp_warn, .temp_recovered, .wake_remote,
      .wake_level, .line_cmp, .txd, .rxd, .normal_mode, .interrupt_out_n, .reset_out_n,
      .standby_request, .sleep_request, .transceiver_off, .transmitter_disable);
   sfw_host_model host (.sys_clk, .avs_waitrequest, .avs_readdata, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .txd, .stuck);
   initial forever #2.5 sys_clk = ~sys_clk;
   task automatic tally_and_finish();
      begin
         if (stuck === 1'b1) n_fail++;
         if (n_fail == 0 && checks > 0) $display("TEST PASSED");
         else $display("TEST FAILED");
         $finish;
      end
   endtask : tally_and_finish
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      begin
         checks++;
         if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask : cmp
   task automatic tick(input int n);
      begin
         repeat (n) @(posedge sys_clk);
      end
   endtask : tick
   task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d);
      begin
         host.access(rd, a, d, q);
         if (stuck === 1'b1) tally_and_finish();
      end
   endtask : bus
   task automatic reset();
      begin
         reset_n <= 1'b0;
         tick(8);
         reset_n <= 1'b1;
         tick(1);
      end
   endtask : reset
   // Counts cycles until the reset output reaches level v, giving up once more than lim cycles have passed.
   task automatic wait_rst(input logic v, input int lim);
      begin
         k = 0;
         while (reset_out_n !== v) begin
            tick(1);
            k++;
            if (k > lim) begin
               n_fail++;
               tally_and_finish();
            end
         end
      end
   endtask : wait_rst
   task automatic remote(input int d, input int r);
      begin
         wake_remote <= 1'b0;
         tick(d);
         wake_remote <= 1'b1;
         tick(r);
      end
   endtask : remote
   initial begin
      reset();
      cmp({interrupt_out_n, reset_out_n, standby_request, sleep_request}, 4'hC);
      host.trigger();
      bus(1'b1, sfw_pkg::ADDR_STATUS, 32'h0);
      cmp(q[1:0], 2'h1);
      // A write without its low byte lane must leave the period alone.
      avs_byteenable <= 4'hE;
      bus(1'b0, sfw_pkg::ADDR_WD_CTRL, 32'h5);
      avs_byteenable <= 4'hF;
      bus(1'b1, sfw_pkg::ADDR_WD_CTRL, 32'h0);
      cmp(q[2:0], 3'h0);
      // With the clock enable low an undervoltage must not reach any flag.
      clk_en <= 1'b0;
      rail_uv <= 4'h1;
      tick(5);
      cmp({standby_request, interrupt_out_n}, 2'h1);
      clk_en <= 1'b1;
      tick(1);
      rail_uv <= 4'hF;
      tick(3);
      bus(1'b1, sfw_pkg::ADDR_SUPPLY, 32'h0);
      cmp(q[7:0], 8'h0F);
      cmp({standby_request, transceiver_off, interrupt_out_n}, 3'h6);
      rail_uv <= 4'h0;
      rail_pok <= 4'hF;
      tick(3);
      bus(1'b1, sfw_pkg::ADDR_SUPPLY, 32'h0);
      cmp({q[7:0], standby_request}, 9'h1E0);
      temp_warn <= 1'b1;
      wake_level <= 1'b1;
      tick(5);
      temp_recovered <= 1'b1;
      remote(20, 300);
      remote(20, 420);
      bus(1'b1, sfw_pkg::ADDR_EVENT, 32'h0);
      cmp(q[3:0], 4'hC);
      remote(20, 10);
      bus(1'b1, sfw_pkg::ADDR_EVENT, 32'h0);
      cmp(q[3:0], 4'hD);
      tick(1300);
      bus(1'b1, sfw_pkg::ADDR_EVENT, 32'h0);
      cmp(q[3:0], 4'hF);
      line_cmp <= 4'hF;
      tick(390);
      bus(1'b1, sfw_pkg::ADDR_BUS, 32'h0);
      cmp(q[6:0], 7'h00);
      tick(20);
      for (int i = 0; i < 3; i++) begin
         if (i == 2) line_cmp <= 4'h0;
         bus(1'b1, sfw_pkg::ADDR_BUS, 32'h0);
         cmp({q[6:0], standby_request}, 8'h1E);
      end
      bus(1'b1, sfw_pkg::ADDR_BUS, 32'h0);
      cmp(q[6:0], 7'h00);
      host.txd_low(160);
      cmp(transmitter_disable, 1'b1);
      tick(3);
      cmp(transmitter_disable, 1'b0);
      bus(1'b1, sfw_pkg::ADDR_BUS, 32'h0);
      cmp(q[6:0], 7'h10);
      fork
         host.txd_low(160);
         begin
            rxd <= 1'b0;
            tick(160);
            rxd <= 1'b1;
         end
      join
      tick(3);
      cmp(transmitter_disable, 1'b1);
      bus(1'b1, sfw_pkg::ADDR_BUS, 32'h0);
      cmp(q[6:4], 3'h7);
      bus(1'b1, sfw_pkg::ADDR_BUS, 32'h0);
      cmp(q[6:5], 2'h1);
      host.probe_short();
      tick(3);
      cmp(transmitter_disable, 1'b0);
      reset();
      normal_mode <= 1'b1;
      host.trigger();
      bus(1'b1, sfw_pkg::ADDR_STATUS, 32'h0);
      cmp(q[1:0], 2'h2);
      tick(36);
      host.trigger();
      bus(1'b0, sfw_pkg::ADDR_WD_CTRL, 32'h3);
      tick(36);
      bus(1'b0, sfw_pkg::ADDR_WD_CTRL, 32'h1);
      tick(30);
      host.trigger();
      bus(1'b1, sfw_pkg::ADDR_WD_CTRL, 32'h0);
      cmp({q[2:0], reset_out_n}, 4'h3);
      regulator1_uv <= 1'b1;
      lo = 1'b1;
      for (int i = 0; i < 300; i++) begin
         tick(1);
         lo = lo & reset_out_n;
      end
      cmp(lo, 1'b1);
      regulator1_uv <= 1'b0;
      wait_rst(1'b0, 200);
      cmp(k >= 110 && k <= 130, 1'b1);
      wait_rst(1'b1, 500);
      bus(1'b1, sfw_pkg::ADDR_STATUS, 32'h0);
      cmp(q[1:0], 2'h0);
      host.trigger();
      host.trigger();
      wait_rst(1'b0, 5);
      reset();
      for (int i = 0; i < 2; i++) begin
         wait_rst(1'b0, 300);
         cmp(k >= 190 && k <= 210, 1'b1);
         wait_rst(1'b1, 500);
      end
      lo = 1'b1;
      for (int i = 0; i < 260; i++) begin
         tick(1);
         lo = lo & reset_out_n;
      end
      cmp({lo, sleep_request}, 2'h3);
      tally_and_finish();
   end
endmodule : sfw_supervisor_flags_watchdog_bench
`default_nettype wire
